// File: hdl/xcb_chain_test.sv
// parity chain board test mode: mode latch, pin isolation and chain output
//
// Behaviour
// (RL1) frame and data bit 0 low at bus reset release enters chain test mode
// (RL2) frame or data bit 0 high at bus reset release leaves chain test mode
// (RL3) core supply power-on reset also clears chain test mode
// (RL4) in chain mode functional logic no longer drives any pin
// (RL5) in chain mode all chain pins are inputs; one pin drives the chain output
// (RL6) flipping any one chain input flips the chain output (parity)
// (RL7) after entry frame and data bit 0 pins are ordinary chain inputs
// (RL8) bus reset pin is never a chain input
// (RL9) supplies, chain output, bus reset and oscillator clock out are excluded
// (RL10) all inputs low gives low output; one input high gives high output
// (RL11) after exit input toggles do not affect the former chain output pin
// (RL12) tester raises inputs descending, then lowers them ascending, checking each step
// (RL13) mode decision latched at each reset release, held until next or power-on
`timescale 1ns/1ps
module xcb_chain_test #(
  parameter int unsigned CHAIN_WIDTH = xcb_pkg::CHAIN_WIDTH
) (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic bus_resetn_i,
  input wire logic core_porn_i,
  // mode strap pins
  input wire logic bus_frame_n_i,
  input wire logic bus_data0_i,
  // other chain pins (bit 0 frame, bit 1 data bit 0 are overridden here)
  input wire logic [CHAIN_WIDTH-1:0] chain_pins_i,
  // functional drive of the shared output pin and of the pin pads
  input wire logic func_chain_out_i,
  input wire logic func_chain_oe_n_i,
  input wire logic [CHAIN_WIDTH-1:0] func_pin_out_i,
  input wire logic [CHAIN_WIDTH-1:0] func_pin_oe_n_i,
  // pad drive
  output logic chain_output_pin_o,
  output logic chain_output_pin_oe_n_o,
  output logic [CHAIN_WIDTH-1:0] pin_out_o,
  output logic [CHAIN_WIDTH-1:0] pin_oe_n_o,
  output logic chain_mode_o
);

  // elaboration check: both strap pins need a slot in the chain
  if (CHAIN_WIDTH < 2) begin : g_bad_width
    $error("CHAIN_WIDTH must be at least 2");
  end

  // synchroniser reset: supply reset and bus reset read as released, straps as idle high,
  // so a bus reset already high at logic reset release makes no false release edge
  localparam logic [CHAIN_WIDTH+3:0] SYNC_IDLE = {4'hf, {CHAIN_WIDTH{1'b0}}};

  // pin synchronisers: first stage read only by second
  logic [CHAIN_WIDTH+3:0] sync1_q, sync1_d;
  logic [CHAIN_WIDTH+3:0] sync2_q, sync2_d;
  logic rst_seen_q, rst_seen_d;
  xcb_pkg::xcb_mode_t mode_q, mode_d;
  logic out_q, out_d;
  logic oe_n_q, oe_n_d;
  logic [CHAIN_WIDTH-1:0] pout_q, pout_d;
  logic [CHAIN_WIDTH-1:0] poe_n_q, poe_n_d;
  logic [CHAIN_WIDTH-1:0] chain_vec;
  logic bus_rst_s, por_s, frame_s, data0_s;

  // synchroniser next values
  always_comb begin
    sync1_d = {core_porn_i, bus_resetn_i, bus_data0_i, bus_frame_n_i, chain_pins_i};
    sync2_d = sync1_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign frame_s = sync2_q[CHAIN_WIDTH];
  assign data0_s = sync2_q[CHAIN_WIDTH+1];
  assign bus_rst_s = sync2_q[CHAIN_WIDTH+2];
  assign por_s = sync2_q[CHAIN_WIDTH+3];

  // strap pins join the chain in slots 0 and 1; bus reset never does
  always_comb begin
    chain_vec = sync2_q[CHAIN_WIDTH-1:0];
    chain_vec[0] = frame_s; // RL7
    chain_vec[1] = data0_s; // RL7 RL8 RL9
  end

  // parity of all chain inputs
  function automatic logic xcb_parity(input logic [CHAIN_WIDTH-1:0] v);
    xcb_parity = ^v;
  endfunction : xcb_parity

  // mode latch: decided at the release of bus reset, cleared at any time by power-on reset
  always_comb begin
    rst_seen_d = bus_rst_s;
    mode_d = mode_q;
    if (!por_s) begin
      mode_d = xcb_pkg::XCB_NORMAL; // RL3
    end else if (bus_rst_s && !rst_seen_q) begin
      // frame low and data0 low selects the chain, else normal
      if (!frame_s && !data0_s) begin
        mode_d = xcb_pkg::XCB_CHAIN; // RL1 RL13
      end else begin
        mode_d = xcb_pkg::XCB_NORMAL; // RL2 RL13
      end
    end
  end

  // pad drive: chain mode cuts functional logic off every pad
  always_comb begin
    if (mode_q == xcb_pkg::XCB_CHAIN) begin
      out_d = xcb_parity(chain_vec); // RL6 RL10
      oe_n_d = 1'b0; // RL5
      pout_d = '0;
      poe_n_d = '1; // RL4 RL5
    end else begin
      out_d = func_chain_out_i; // RL11
      oe_n_d = func_chain_oe_n_i;
      pout_d = func_pin_out_i;
      poe_n_d = func_pin_oe_n_i;
    end
  end

  // state registers; bus reset edge tracker starts high so no false edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rst_seen_q <= 1'b1;
      mode_q <= xcb_pkg::XCB_NORMAL;
      out_q <= xcb_pkg::CHAIN_OUT_IDLE;
      oe_n_q <= 1'b1;
      pout_q <= '0;
      poe_n_q <= '1;
    end else begin
      rst_seen_q <= rst_seen_d;
      mode_q <= mode_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      pout_q <= pout_d;
      poe_n_q <= poe_n_d;
    end
  end

  assign chain_output_pin_o = out_q;
  assign chain_output_pin_oe_n_o = oe_n_q;
  assign pin_out_o = pout_q;
  assign pin_oe_n_o = poe_n_q;
  assign chain_mode_o = mode_q;

  // assertions
  sequence s_release_low;
    $rose(bus_rst_s) && por_s && !frame_s && !data0_s;
  endsequence

  sequence s_release_high;
    $rose(bus_rst_s) && por_s && (frame_s || data0_s);
  endsequence

  property p_enter;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_release_low |=> chain_mode_o;
  endproperty
  a_enter: assert property (p_enter) else $error("chain mode not entered"); // RL1

  property p_exit;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_release_high |=> !chain_mode_o;
  endproperty
  a_exit: assert property (p_exit) else $error("chain mode not left"); // RL2

  property p_por;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !por_s |=> !chain_mode_o;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset kept chain mode"); // RL3

  property p_isolate;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $past(chain_mode_o) && chain_mode_o |-> (pin_oe_n_o == '1);
  endproperty
  a_isolate: assert property (p_isolate) else $error("pad driven in chain mode"); // RL4

  property p_out_drive;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_mode_o |=> !chain_output_pin_oe_n_o;
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("chain output not driven"); // RL5

  property p_parity;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_mode_o && $stable(chain_mode_o) |=> chain_output_pin_o == $past(^chain_vec);
  endproperty
  a_parity: assert property (p_parity) else $error("chain output wrong parity"); // RL6

  property p_strap_in_chain;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_mode_o && $stable(chain_mode_o) && $changed(frame_s) && $stable(bus_rst_s)
      && $stable(chain_vec[CHAIN_WIDTH-1:1])
      |=> chain_output_pin_o != $past(chain_output_pin_o);
  endproperty
  a_strap_in_chain: assert property (p_strap_in_chain) else $error("frame not in chain"); // RL7

  property p_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    por_s && !$rose(bus_rst_s) |=> $stable(chain_mode_o);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without reset edge"); // RL13

  property p_exit_quiet;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !chain_mode_o |=> chain_output_pin_o == $past(func_chain_out_i);
  endproperty
  a_exit_quiet: assert property (p_exit_quiet) else $error("chain leaks after exit"); // RL11

  // the former chain output follows only its functional source after exit
  property p_exit_still;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $past(resetn_i) && !chain_mode_o && $stable(chain_mode_o) && $stable(func_chain_out_i)
      |=> $stable(chain_output_pin_o);
  endproperty
  a_exit_still: assert property (p_exit_still) else $error("chain pins moved old output"); // RL11

  // functional drive returns to every pad once the chain is left
  property p_func_restore;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !chain_mode_o |=> (pin_out_o == $past(func_pin_out_i))
      && (pin_oe_n_o == $past(func_pin_oe_n_i))
      && (chain_output_pin_oe_n_o == $past(func_chain_oe_n_i));
  endproperty
  a_func_restore: assert property (p_func_restore) else $error("pads not returned"); // RL2 RL3

  // chain mode: no functional data reaches the pads either
  property p_isolate_data;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $past(chain_mode_o) && chain_mode_o |-> (pin_out_o == '0);
  endproperty
  a_isolate_data: assert property (p_isolate_data) else $error("pad data in chain mode"); // RL4

  // all chain inputs low give a low output; a single high input gives a high output
  property p_all_low;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_mode_o && (chain_vec == '0) |=> !chain_output_pin_o;
  endproperty
  a_all_low: assert property (p_all_low) else $error("all low chain not low"); // RL10

  property p_one_high;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_mode_o && $onehot(chain_vec) |=> chain_output_pin_o;
  endproperty
  a_one_high: assert property (p_one_high) else $error("one high chain not high"); // RL10

  // only the bus reset pin moves while the chain is active: the output must not follow it
  sequence s_bus_rst_only;
    chain_mode_o && $stable(chain_mode_o) && $changed(bus_rst_s) && $stable(frame_s)
      && $stable(data0_s) && $stable(sync2_q[CHAIN_WIDTH-1:2]);
  endsequence

  property p_rst_outside;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_bus_rst_only |=> $stable(chain_output_pin_o);
  endproperty
  a_rst_outside: assert property (p_rst_outside) else $error("bus reset reached chain"); // RL8

  // end to end: the pad shows the parity of the chain pins three clocks back,
  // built from the pins themselves so a miswired slot cannot hide
  sequence s_chain_settled;
    $past(chain_mode_o) && $past(resetn_i) && $past(resetn_i, 2) && $past(resetn_i, 3);
  endsequence

  property p_pin_to_pad;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_chain_settled |-> chain_output_pin_o
      == $past(bus_frame_n_i ^ bus_data0_i ^ (^chain_pins_i[CHAIN_WIDTH-1:2]), 3);
  endproperty
  a_pin_to_pad: assert property (p_pin_to_pad) else $error("pad parity wrong"); // RL6 RL7 RL8 RL9

  // the mode moves only one clock after a synced release or during power-on reset
  property p_change_cause;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $past(resetn_i) && $changed(chain_mode_o)
      |-> $past(!por_s) || ($past(bus_rst_s) && !$past(bus_rst_s, 2));
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("mode moved without cause"); // RL13

  // pin level: a release decides the mode three clocks later;
  // the two synchroniser stages cost two of those clocks
  sequence s_pin_release_low;
    $past(resetn_i) && $rose(bus_resetn_i) && !bus_frame_n_i && !bus_data0_i && core_porn_i;
  endsequence

  sequence s_pin_release_high;
    $past(resetn_i) && $rose(bus_resetn_i) && (bus_frame_n_i || bus_data0_i);
  endsequence

  property p_pin_enter;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_pin_release_low |-> ##3 chain_mode_o;
  endproperty
  a_pin_enter: assert property (p_pin_enter) else $error("pin release did not enter"); // RL1 RL13

  property p_pin_exit;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_pin_release_high |-> ##3 !chain_mode_o;
  endproperty
  a_pin_exit: assert property (p_pin_exit) else $error("pin release did not leave"); // RL2 RL13

endmodule : xcb_chain_test

// File: hdl/xcb_pkg.sv
// package for the board-level parity chain test logic
package xcb_pkg;
  // number of pins that feed the parity chain
  localparam int unsigned CHAIN_WIDTH = 32'd16;
  // mode flag after logic reset or power-on reset
  localparam logic MODE_RESET = 1'b0;
  // chain output level loaded by logic reset
  localparam logic CHAIN_OUT_IDLE = 1'b0;
  // mode latch states
  typedef enum logic [0:0] {
    XCB_NORMAL = 1'b0,
    XCB_CHAIN = 1'b1
  } xcb_mode_t;
endpackage : xcb_pkg

// File: tb/xcb_tester.sv
// board tester model: drives straps, bus reset and chain pins
`timescale 1ns/1ps
module xcb_tester #(
  parameter int W = xcb_pkg::CHAIN_WIDTH
) (
  // clock
  input wire logic ref_clk_i,
  // tester drive
  output logic bus_resetn_o,
  output logic bus_frame_n_o,
  output logic bus_data0_o,
  output logic [W-1:0] chain_pins_o
);
  // chain pins tied low and straps high at setup, bus reset held
  initial begin
    bus_resetn_o = 1'b0;
    bus_frame_n_o = 1'b1;
    bus_data0_o = 1'b1;
    chain_pins_o = '0;
  end
  // straps stay put four clocks on each side of the release edge
  task automatic release_reset(input logic f, input logic d);
    @(negedge ref_clk_i);
    bus_resetn_o = 1'b0;
    bus_frame_n_o = f;
    bus_data0_o = d;
    repeat (4) @(negedge ref_clk_i);
    bus_resetn_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask : release_reset
  // slot 0 frame, slot 1 data bit 0; unused slots get the inverse to catch misuse
  task automatic put(input logic [W-1:0] v);
    @(negedge ref_clk_i);
    bus_frame_n_o = v[0];
    bus_data0_o = v[1];
    chain_pins_o = {v[W-1:2], ~v[1:0]};
    repeat (5) @(negedge ref_clk_i);
  endtask : put
endmodule : xcb_tester

// File: tb/xnor_chain_board_test_test.sv
// self-checking bench for the parity chain board test mode
`timescale 1ns/1ps
module xnor_chain_board_test_test;
  localparam int W = xcb_pkg::CHAIN_WIDTH;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic core_porn_i = 1'b1;
  logic func_out = 1'b1;
  logic func_oe_n = 1'b1;
  logic [W-1:0] func_pin = 16'hA5C3;
  logic [W-1:0] func_oe = 16'h0F0F;
  logic bus_resetn, frame_n, data0, c_out, c_oe_n, mode;
  logic [W-1:0] pins, p_out, p_oe_n;
  int n_mismatch = 0;
  int compares = 0;
  // 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;
  xcb_tester #(.W(W)) i_xcb_tester (.ref_clk_i(ref_clk_i), .bus_resetn_o(bus_resetn),
    .bus_frame_n_o(frame_n), .bus_data0_o(data0), .chain_pins_o(pins));
  xcb_chain_test #(.CHAIN_WIDTH(W)) i_xcb_chain_test (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .bus_resetn_i(bus_resetn), .core_porn_i(core_porn_i),
    .bus_frame_n_i(frame_n), .bus_data0_i(data0), .chain_pins_i(pins),
    .func_chain_out_i(func_out), .func_chain_oe_n_i(func_oe_n), .func_pin_out_i(func_pin),
    .func_pin_oe_n_i(func_oe), .chain_output_pin_o(c_out), .chain_output_pin_oe_n_o(c_oe_n),
    .pin_out_o(p_out), .pin_oe_n_o(p_oe_n), .chain_mode_o(mode));
  // single comparison point; one-bit values widen with zeros
  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic enter_mode;
    i_xcb_tester.release_reset(1'b0, 1'b0);
    check("mode", mode, 1);
    check("pin oe_n", p_oe_n, '1);
    check("pin out", p_out, 0);
    check("chain oe_n", c_oe_n, 0);
  endtask : enter_mode
  // raise descending, lower ascending; parity flips at every step
  task automatic walk;
    logic [W-1:0] v;
    v = '0;
    i_xcb_tester.put(v);
    check("chain all low", c_out, 0);
    for (int i = W - 1; i >= 0; i--) begin
      v[i] = 1'b1;
      i_xcb_tester.put(v);
      check("chain rise", c_out, ^v);
    end
    for (int i = 0; i < W; i++) begin
      v[i] = 1'b0;
      i_xcb_tester.put(v);
      check("chain fall", c_out, ^v);
    end
  endtask : walk
  // a second entry edge keeps the mode; bus reset toggling is not seen on the chain
  task automatic hold_mode;
    i_xcb_tester.put(16'h0004);
    i_xcb_tester.release_reset(1'b0, 1'b0);
    check("mode held", mode, 1);
    check("chain vs bus reset", c_out, 1);
  endtask : hold_mode
  task automatic exit_mode;
    i_xcb_tester.release_reset(1'b1, 1'b0);
    check("mode", mode, 0);
    i_xcb_tester.put(16'h8001);
    check("old chain out", c_out, func_out);
    check("pin out", p_out, func_pin);
    check("pin oe_n", p_oe_n, func_oe);
    check("chain oe_n", c_oe_n, func_oe_n);
  endtask : exit_mode
  task automatic power_on;
    enter_mode();
    @(negedge ref_clk_i);
    core_porn_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    check("mode", mode, 0);
    check("pads back", p_oe_n, func_oe);
    core_porn_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    check("mode", mode, 0);
  endtask : power_on
  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    check("mode after reset", mode, 0);
    enter_mode();
    walk();
    hold_mode();
    exit_mode();
    power_on();
    give_verdict();
  end
endmodule : xnor_chain_board_test_test
